/* File: hw/agc_pkg.sv */
// Constants, codes and tables shared by the gain loop modules
// Function
// R1 - Threshold code 1000 disables the absolute carrier-sense test completely.
// R2 - Other threshold codes sit signed -7..+7 dB from the amplitude goal.
// R3 - Two-bit deadzone select, codes none/low/medium/large, reset code 2.
// R4 - After each gain step skip 8/16/24/32 samples, default 16.
// R5 - Hold policy 0, the reset value: adjust gain whenever needed.
// R6 - Hold policy 1: hold gain once a sync word is found.
// R7 - Hold policy 2: analogue gain fixed, digital gain keeps adjusting.
// R8 - Hold policy 3: both gains fixed, manual override allowed.
// R9 - Frequency-shift modes average 8/16/32/64 samples, field reset code 1.
// R10 - On-off keying: same field selects 4/8/12/16 dB decision boundary.
// R11 - Sense compares channel filter amplitude while gain is not reduced.
// R12 - Loop regulates averaged amplitude to goal 24..42 dB, default code 3.
// R13 - Carrier sense only above an enabled absolute threshold, never when disabled.
package agc_pkg;
   // Register indices; byte address is four times the index
   localparam logic [5:0] AGC_IDX_GOAL = 6'h1B;
   localparam logic [5:0] AGC_IDX_THR = 6'h1C;
   localparam logic [5:0] AGC_IDX_CTRL = 6'h1D;
   localparam logic [5:0] AGC_IDX_STATUS = 6'h30;
   localparam logic [5:0] AGC_IDX_MASK = 6'h31;
   localparam logic [5:0] AGC_IDX_GAIN = 6'h32;
   localparam logic [5:0] AGC_IDX_MANUAL = 6'h33;
   // Reset values
   localparam logic [7:0] AGC_CTRL_RESET = 8'h91;
   localparam logic [3:0] AGC_THR_RESET = 4'h0;
   localparam logic [2:0] AGC_GOAL_RESET = 3'h3;
   localparam logic [7:0] AGC_MANUAL_RESET = 8'hFF;
   // Control field positions
   localparam int AGC_HYST_HI = 7;
   localparam int AGC_HYST_LO = 6;
   localparam int AGC_WAIT_HI = 5;
   localparam int AGC_WAIT_LO = 4;
   localparam int AGC_HOLD_HI = 3;
   localparam int AGC_HOLD_LO = 2;
   localparam int AGC_LEN_HI = 1;
   localparam int AGC_LEN_LO = 0;
   localparam int AGC_MAN_ANA_LO = 4;
   localparam int AGC_MAN_DIG_LO = 0;
   // Gain hold policies
   localparam logic [1:0] AGC_HOLD_NONE = 2'h0;
   localparam logic [1:0] AGC_HOLD_SYNC = 2'h1;
   localparam logic [1:0] AGC_HOLD_ANALOG = 2'h2;
   localparam logic [1:0] AGC_HOLD_ALL = 2'h3;
   localparam logic [3:0] AGC_THR_DISABLED = 4'h8;
   // Status bits
   localparam int AGC_ST_W = 3;
   localparam int AGC_ST_SENSE = 0;
   localparam int AGC_ST_GAIN = 1;
   localparam int AGC_ST_SYNC = 2;
   // Sample counts and scales
   localparam logic [5:0] AGC_WAIT_UNIT = 6'h08;
   localparam logic [6:0] AGC_AVG_BASE = 7'h08;
   localparam logic [3:0] AGC_AVG_SHIFT = 4'h3;
   localparam logic [1:0] AGC_OOK_LEN = 2'h1;
   localparam logic [7:0] AGC_BOUND_UNIT_DB = 8'h04;
   localparam int AGC_GAIN_W = 4;
   localparam logic [3:0] AGC_GAIN_MAX = 4'hF;
   localparam logic [7:0] AGC_ANA_STEP_DB = 8'h06;
   localparam logic [7:0] AGC_DIG_STEP_DB = 8'h03;
   // Goal in dB per code, code 0 in the low byte
   localparam logic [63:0] AGC_GOAL_TABLE = 64'h2A28_2624_211E_1B18;
   // Deadzone above and below goal, and gain steps, per deadzone code
   localparam logic [31:0] AGC_HYST_UP_TABLE = 32'h0402_0101;
   localparam logic [31:0] AGC_HYST_DN_TABLE = 32'h0804_0201;
   localparam logic [15:0] AGC_STEP_TABLE = 16'h1112;
   typedef enum logic [1:0] {
      AGC_SETTLE = 2'b00,
      AGC_ACCUM = 2'b01,
      AGC_ADJUST = 2'b11
   } agc_state_e;
endpackage : agc_pkg

/* File: hw/agc_avg.sv */
// Channel filter amplitude averager over a power-of-two sample count
`timescale 1ns/1ps
module agc_avg
   import agc_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Samples
   input wire logic clear,
   input wire logic take,
   input wire logic [7:0] amp,
   input wire logic [1:0] len_code,
   // Result
   output logic avg_valid,
   output logic [7:0] avg_amp
);
   typedef struct packed {
      logic [14:0] sum;
      logic [6:0] cnt;
      logic [7:0] avg;
      logic done;
   } agc_avg_s;
   agc_avg_s r, next_r;
   logic [6:0] target;
   logic [3:0] shift;
   logic [14:0] total;

   always_comb begin
      target = 7'(AGC_AVG_BASE << len_code); // [R9]
      shift = AGC_AVG_SHIFT + {2'h0, len_code};
      total = r.sum + {7'h0, amp};
      next_r = r;
      next_r.done = 1'b0;
      if (clear) begin
         next_r.sum = '0;
         next_r.cnt = '0;
      end else if (take) begin
         if (r.cnt == target - 7'h01) begin
            next_r.avg = 8'(total >> shift); // [R9]
            next_r.done = 1'b1;
            next_r.sum = '0;
            next_r.cnt = '0;
         end else begin
            next_r.sum = total;
            next_r.cnt = r.cnt + 7'h01;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign avg_valid = r.done;
   assign avg_amp = r.avg;

   a_avg_count: assert property (@(posedge clk) disable iff (rst) // [R9]
      r.done |-> $past(r.cnt) == $past(target) - 7'h01 && $past(take))
      else $error("average produced after wrong sample count");
endmodule : agc_avg

/* File: hw/agc_sense.sv */
// Absolute carrier-sense comparison against the amplitude goal
`timescale 1ns/1ps
module agc_sense
   import agc_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Measurement
   input wire logic [7:0] amp,
   input wire logic [7:0] reduction,
   input wire logic [7:0] goal_db,
   input wire logic [3:0] thr,
   // Result
   output logic sense
);
   typedef struct packed {
      logic sense;
   } agc_sense_s;
   agc_sense_s r, next_r;
   logic [8:0] rssi;
   logic signed [9:0] level;

   always_comb begin
      // Gain cut is added back, so unreduced gain compares the raw amplitude
      rssi = {1'b0, amp} + {1'b0, reduction}; // [R11]
      level = $signed({2'b00, goal_db}) + $signed({{6{thr[3]}}, thr}); // [R2]
      next_r.sense = (thr != AGC_THR_DISABLED) && ($signed({1'b0, rssi}) > level); // [R1] [R13]
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign sense = r.sense;
endmodule : agc_sense

/* File: hw/agc_gain_loop.sv */
// Gain loop with Wishbone registers, freeze policy, sense and interrupt
//
// Implementation choice: register access over Wishbone.
`timescale 1ns/1ps
module agc_gain_loop
   import agc_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Channel filter and demodulator
   input wire logic sample_valid,
   input wire logic [7:0] sample_amp,
   input wire logic sync_found,
   input wire logic rx_restart,
   input wire logic ook_mode,
   // Gain, sense and decisions
   output logic [AGC_GAIN_W-1:0] analog_gain,
   output logic [AGC_GAIN_W-1:0] digital_gain,
   output logic carrier_sense,
   output logic ook_data,
   output logic irq
);
   typedef struct packed {
      logic ack;
      logic [31:0] rdata;
      logic [7:0] ctrl;
      logic [3:0] thr;
      logic [2:0] goal;
      logic [7:0] manual;
      logic [AGC_ST_W-1:0] status;
      logic [AGC_ST_W-1:0] mask;
      agc_state_e state;
      logic [5:0] wait_cnt;
      logic [7:0] avg_hold;
      logic [AGC_GAIN_W-1:0] ana;
      logic [AGC_GAIN_W-1:0] dig;
      logic sync_hold;
      logic cs;
      logic ook;
      logic irq;
   } agc_top_s;
   agc_top_s r, next_r;

   logic [1:0] hyst, wait_code, hold, len_code;
   logic [5:0] wait_target;
   logic [7:0] goal_db, hyst_up, hyst_dn, bound_db, reduction;
   logic [3:0] step;
   logic ana_ok, dig_ok, too_high, too_low, gain_moved;
   logic access, wr, rd;
   logic [5:0] idx;
   logic [7:0] rd_byte;
   logic [AGC_ST_W-1:0] st_set, st_clr;
   logic avg_valid, sense;
   logic [7:0] avg_amp;
   logic [4:0] ana_dn, ana_up, dig_dn, dig_up;

   agc_avg u_avg (
      .clk(clk),
      .rst(rst),
      .clear(gain_moved),
      .take(sample_valid && r.state == AGC_ACCUM),
      .amp(sample_amp),
      .len_code(ook_mode ? AGC_OOK_LEN : len_code),
      .avg_valid(avg_valid),
      .avg_amp(avg_amp)
   );

   agc_sense u_sense (
      .clk(clk),
      .rst(rst),
      .amp(r.avg_hold),
      .reduction(reduction),
      .goal_db(goal_db),
      .thr(r.thr),
      .sense(sense)
   );

   always_comb begin
      hyst = r.ctrl[AGC_HYST_HI:AGC_HYST_LO]; // [R3]
      wait_code = r.ctrl[AGC_WAIT_HI:AGC_WAIT_LO];
      hold = r.ctrl[AGC_HOLD_HI:AGC_HOLD_LO];
      len_code = r.ctrl[AGC_LEN_HI:AGC_LEN_LO];
      wait_target = 6'(AGC_WAIT_UNIT * ({4'h0, wait_code} + 6'h01)); // [R4]
      goal_db = AGC_GOAL_TABLE[{r.goal, 3'h0} +: 8]; // [R12]
      hyst_up = AGC_HYST_UP_TABLE[{hyst, 3'h0} +: 8]; // [R3]
      hyst_dn = AGC_HYST_DN_TABLE[{hyst, 3'h0} +: 8];
      step = AGC_STEP_TABLE[{hyst, 2'h0} +: 4];
      bound_db = 8'(AGC_BOUND_UNIT_DB * ({6'h00, len_code} + 8'h01)); // [R10]
      reduction = 8'({4'h0, AGC_GAIN_MAX - r.ana}) * AGC_ANA_STEP_DB
         + 8'({4'h0, AGC_GAIN_MAX - r.dig}) * AGC_DIG_STEP_DB;
      // Policy decides which gain stages may move
      ana_ok = (hold == AGC_HOLD_NONE) || (hold == AGC_HOLD_SYNC && !r.sync_hold); // [R5] [R6]
      dig_ok = ana_ok || (hold == AGC_HOLD_ANALOG); // [R7]
      too_high = {1'b0, r.avg_hold} > {1'b0, goal_db} + {1'b0, hyst_up}; // [R12]
      too_low = {1'b0, r.avg_hold} + {1'b0, hyst_dn} < {1'b0, goal_db};
      ana_dn = ({1'b0, r.ana} > {1'b0, step}) ? {1'b0, r.ana} - {1'b0, step} : 5'h00;
      dig_dn = ({1'b0, r.dig} > {1'b0, step}) ? {1'b0, r.dig} - {1'b0, step} : 5'h00;
      ana_up = {1'b0, r.ana} + {1'b0, step};
      dig_up = {1'b0, r.dig} + {1'b0, step};
      if (ana_up > {1'b0, AGC_GAIN_MAX}) begin
         ana_up = {1'b0, AGC_GAIN_MAX};
      end
      if (dig_up > {1'b0, AGC_GAIN_MAX}) begin
         dig_up = {1'b0, AGC_GAIN_MAX};
      end
      // Bus decode; one wait state, ack drops the cycle after it rose
      access = wb_cyc_i && wb_stb_i && !r.ack;
      wr = access && wb_we_i && wb_sel_i[0];
      rd = access && !wb_we_i;
      idx = wb_adr_i[7:2];
      unique case (idx)
         AGC_IDX_GOAL: rd_byte = {5'h00, r.goal};
         AGC_IDX_THR: rd_byte = {4'h0, r.thr};
         AGC_IDX_CTRL: rd_byte = r.ctrl;
         AGC_IDX_STATUS: rd_byte = {{(8 - AGC_ST_W){1'b0}}, r.status};
         AGC_IDX_MASK: rd_byte = {{(8 - AGC_ST_W){1'b0}}, r.mask};
         AGC_IDX_GAIN: rd_byte = {r.ana, r.dig};
         AGC_IDX_MANUAL: rd_byte = r.manual;
         default: rd_byte = 8'h00;
      endcase

      next_r = r;
      gain_moved = 1'b0;
      st_set = '0;
      st_clr = '0;
      next_r.ack = access;
      if (access) begin
         next_r.rdata = rd ? {24'h000000, rd_byte} : 32'h00000000;
      end
      if (wr) begin
         unique case (idx)
            AGC_IDX_GOAL: next_r.goal = wb_dat_i[2:0];
            AGC_IDX_THR: next_r.thr = wb_dat_i[3:0];
            AGC_IDX_CTRL: next_r.ctrl = wb_dat_i[7:0];
            AGC_IDX_MASK: next_r.mask = wb_dat_i[AGC_ST_W-1:0];
            AGC_IDX_MANUAL: next_r.manual = wb_dat_i[7:0];
            default: next_r.goal = r.goal;
         endcase
      end
      if (rd && idx == AGC_IDX_STATUS) begin
         st_clr = r.status;
      end

      // Sync latch; a new sync beats a restart in the same cycle
      if (rx_restart) begin
         next_r.sync_hold = 1'b0;
      end
      if (sync_found) begin
         next_r.sync_hold = 1'b1; // [R6]
         if (hold == AGC_HOLD_SYNC && !r.sync_hold) begin
            st_set[AGC_ST_SYNC] = 1'b1;
         end
      end

      unique case (r.state)
         AGC_SETTLE: begin
            if (sample_valid) begin
               if (r.wait_cnt == wait_target - 6'h01) begin // [R4]
                  next_r.wait_cnt = '0;
                  next_r.state = AGC_ACCUM;
               end else begin
                  next_r.wait_cnt = r.wait_cnt + 6'h01;
               end
            end
         end
         AGC_ACCUM: begin
            if (avg_valid) begin
               next_r.avg_hold = avg_amp; // [R9]
               next_r.state = AGC_ADJUST;
            end
         end
         AGC_ADJUST: begin
            next_r.state = AGC_ACCUM;
            // Analogue stage moves first; digital picks up under analogue hold or when analogue is at its limit
            if (too_high) begin
               if (ana_ok && r.ana != '0) begin
                  next_r.ana = ana_dn[AGC_GAIN_W-1:0]; // [R5]
                  gain_moved = 1'b1;
               end else if (dig_ok && r.dig != '0) begin
                  next_r.dig = dig_dn[AGC_GAIN_W-1:0]; // [R7]
                  gain_moved = 1'b1;
               end
            end else if (too_low) begin
               if (ana_ok && r.ana != AGC_GAIN_MAX) begin
                  next_r.ana = ana_up[AGC_GAIN_W-1:0];
                  gain_moved = 1'b1;
               end else if (dig_ok && r.dig != AGC_GAIN_MAX) begin
                  next_r.dig = dig_up[AGC_GAIN_W-1:0];
                  gain_moved = 1'b1;
               end
            end
            if (gain_moved) begin
               next_r.state = AGC_SETTLE; // [R4]
               next_r.wait_cnt = '0;
               st_set[AGC_ST_GAIN] = 1'b1;
            end
         end
         default: next_r.state = AGC_SETTLE;
      endcase

      // Full hold follows the override register instead of the loop
      if (hold == AGC_HOLD_ALL) begin
         next_r.ana = r.manual[AGC_MAN_ANA_LO +: AGC_GAIN_W]; // [R8]
         next_r.dig = r.manual[AGC_MAN_DIG_LO +: AGC_GAIN_W];
      end

      next_r.cs = sense; // [R13]
      if (sense && !r.cs) begin
         st_set[AGC_ST_SENSE] = 1'b1;
      end
      if (sample_valid) begin
         // Amplitude within the boundary below goal counts as a mark
         next_r.ook = ook_mode && ({1'b0, sample_amp} + {1'b0, bound_db} >= {1'b0, goal_db}); // [R10]
      end
      // Set wins over the read-clear
      next_r.status = (r.status & ~st_clr) | st_set;
      next_r.irq = |(next_r.status & next_r.mask);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         r <= '0;
         r.ctrl <= AGC_CTRL_RESET; // [R3] [R4] [R5] [R9]
         r.thr <= AGC_THR_RESET;
         r.goal <= AGC_GOAL_RESET; // [R12]
         r.manual <= AGC_MANUAL_RESET;
         r.ana <= AGC_GAIN_MAX;
         r.dig <= AGC_GAIN_MAX;
         r.state <= AGC_ACCUM;
      end else begin
         r <= next_r;
      end
   end

   assign wb_ack_o = r.ack;
   assign wb_dat_o = r.rdata;
   assign analog_gain = r.ana;
   assign digital_gain = r.dig;
   assign carrier_sense = r.cs;
   assign ook_data = r.ook;
   assign irq = r.irq;

   // Reference sense level for checking only
   logic [8:0] chk_rssi;
   logic signed [9:0] chk_level;
   logic chk_cs;
   always_comb begin
      chk_rssi = {1'b0, r.avg_hold} + {1'b0, reduction};
      chk_level = $signed({2'b00, goal_db}) + $signed({{6{r.thr[3]}}, r.thr});
      chk_cs = (r.thr != AGC_THR_DISABLED) && ($signed({1'b0, chk_rssi}) > chk_level);
   end

   default clocking agc_cb @(posedge clk);
   endclocking
   default disable iff (rst);

   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   a_thr_off: assert property ($past(r.thr, 2) == AGC_THR_DISABLED |-> !carrier_sense) // [R1]
      else $error("sense raised with absolute test disabled");
   a_sense_level: assert property (##2 carrier_sense == $past(chk_cs, 2)) // [R2]
      else $error("sense does not match signed threshold");
   a_ctrl_reset: assert property ($past(rst) |-> r.ctrl == AGC_CTRL_RESET) // [R3]
      else $error("control register reset value wrong");
   a_settle_len: assert property ( // [R4]
      (r.state == AGC_ACCUM && $past(r.state) == AGC_SETTLE) |->
      $past(sample_valid) && $past(r.wait_cnt) == $past(wait_target) - 6'h01)
      else $error("settle left after wrong sample count");
   a_normal_down: assert property ( // [R5]
      (r.state == AGC_ADJUST && hold == AGC_HOLD_NONE && too_high && r.ana != '0) |=>
      analog_gain < $past(analog_gain))
      else $error("normal policy did not lower gain");
   a_sync_hold: assert property ( // [R6]
      (hold == AGC_HOLD_SYNC && r.sync_hold) ##1 (hold == AGC_HOLD_SYNC) |->
      $stable(analog_gain) && $stable(digital_gain))
      else $error("gain moved after sync hold");
   a_analog_hold: assert property ( // [R7]
      (hold == AGC_HOLD_ANALOG) ##1 (hold == AGC_HOLD_ANALOG) |-> $stable(analog_gain))
      else $error("analogue gain moved under analogue hold");
   a_manual_hold: assert property ( // [R8]
      hold == AGC_HOLD_ALL |=> analog_gain == $past(r.manual[AGC_MAN_ANA_LO +: AGC_GAIN_W])
      && digital_gain == $past(r.manual[AGC_MAN_DIG_LO +: AGC_GAIN_W]))
      else $error("manual gain not applied");
   a_irq_level: assert property (irq == |(r.status & r.mask))
      else $error("interrupt does not follow masked status");

   // Bus answer and status flags
   a_ack_answer: assert property (
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not answered in one cycle");
   a_write_zero: assert property (
      wb_ack_o && $past(wb_we_i) |-> wb_dat_o == '0)
      else $error("read data not cleared by a write");
   a_status_clear: assert property (
      rd && idx == AGC_IDX_STATUS && st_set == '0 |=> r.status == '0)
      else $error("status not cleared by its read");
   a_gain_flag: assert property (
      gain_moved |=> r.status[AGC_ST_GAIN])
      else $error("gain step not flagged");
   a_sense_flag: assert property ( // [R13]
      sense && !r.cs |=> r.status[AGC_ST_SENSE])
      else $error("sense rise not flagged");
   a_sync_flag: assert property ( // [R6]
      sync_found && hold == AGC_HOLD_SYNC && !r.sync_hold |=> r.status[AGC_ST_SYNC])
      else $error("sync hold not flagged");
   a_sync_clear: assert property ( // [R6]
      rx_restart && !sync_found |=> !r.sync_hold)
      else $error("restart did not release sync hold");

   // Loop sequencing and gain steps
   a_settle_enter: assert property ( // [R4]
      gain_moved |=> r.state == AGC_SETTLE && r.wait_cnt == '0)
      else $error("settle not restarted after gain step");
   a_avg_latch: assert property ( // [R9]
      r.state == AGC_ACCUM && avg_valid |=> r.state == AGC_ADJUST
      && r.avg_hold == $past(avg_amp))
      else $error("average not taken into adjust");
   a_dead_zone: assert property ( // [R3]
      r.state == AGC_ADJUST && hold != AGC_HOLD_ALL && !too_high && !too_low |=>
      $stable(analog_gain) && $stable(digital_gain))
      else $error("gain moved inside dead zone");
   a_normal_up: assert property ( // [R5]
      r.state == AGC_ADJUST && ana_ok && too_low && r.ana != AGC_GAIN_MAX |=>
      analog_gain > $past(analog_gain))
      else $error("low amplitude did not raise gain");
   a_digital_step: assert property ( // [R7]
      r.state == AGC_ADJUST && hold == AGC_HOLD_ANALOG && too_high && r.dig != '0 |=>
      digital_gain < $past(digital_gain))
      else $error("digital gain did not step under analogue hold");
   a_no_cut: assert property ( // [R11]
      analog_gain == AGC_GAIN_MAX && digital_gain == AGC_GAIN_MAX |-> reduction == '0)
      else $error("reduction seen at full gain");
   a_ook_off: assert property ( // [R10]
      sample_valid && !ook_mode |=> !ook_data)
      else $error("keying decision outside keying mode");
endmodule : agc_gain_loop

/* File: testbench/agc_tb.sv */
// Self-checking bench for the gain loop block
`timescale 1ns/1ps
module testbench;
   import agc_pkg::*;
   logic clk, rst, cyc, stb, we, sv, sync_found, rx_restart, ook_mode;
   logic [7:0] adr, amp, av, m;
   logic [3:0] sel, ana, dig, tc;
   logic [31:0] dat_i, dat_o, rd;
   logic ack, cs, ook_data, irq;
   logic [31:0] seed = 32'h0000_FF9B;
   int num_errors = 0;
   int checks_done = 0;
   int n1, n2, l, h;
   // Goal in dB per code, and the register map seen by software
   logic [7:0] goal_db [8] = '{8'h18, 8'h1B, 8'h1E, 8'h21, 8'h24, 8'h26, 8'h28, 8'h2A};
   logic [7:0] ra [8] = '{8'h6C, 8'h70, 8'h74, 8'hC0, 8'hC4, 8'hC8, 8'hCC, 8'h00};
   logic [7:0] rv [8] = '{8'h03, 8'h00, 8'h91, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00};
   logic [7:0] rm [8] = '{8'h07, 8'h0F, 8'hFF, 8'h00, 8'h07, 8'h00, 8'hFF, 8'h00};

   agc_gain_loop dut (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_i), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .sample_valid(sv), .sample_amp(amp), .sync_found(sync_found),
      .rx_restart(rx_restart), .ook_mode(ook_mode), .analog_gain(ana),
      .digital_gain(dig), .carrier_sense(cs), .ook_data(ook_data), .irq(irq));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd

   function automatic logic exp_sense(logic [3:0] thr, logic [7:0] a, logic [7:0] g);
      int t;
      t = $signed(thr);
      return (thr != 4'h8) && (int'(a) > int'(g) + t);
   endfunction : exp_sense

   function automatic logic exp_ook(logic [7:0] a, int len, logic [7:0] g);
      return int'(a) + 4 * (len + 1) >= int'(g);
   endfunction : exp_ook

   task automatic complete_run();
      $display("Checks %0d, errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : complete_run

   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %0h seen %0h", name, exp, got);
      end
   endtask : check

   task automatic do_reset();
      @(posedge clk);
      rst <= 1'b1;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
   endtask : do_reset

   // One classic cycle; the request stands until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                     input logic [3:0] s);
      int i;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat_i <= {24'h0, d};
      sel <= s;
      i = 0;
      do begin
         @(posedge clk);
         i++;
      end while (ack !== 1'b1 && i < 20);
      rd = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (ack !== 1'b1) begin
         num_errors++;
         $display("[ERR] wb_ack_o expected 1 seen %b", ack);
         complete_run();
      end
   endtask : wb

   // Spaced samples, so none lands in the adjust cycle
   task automatic feed(input logic [7:0] a, input int cnt);
      repeat (cnt) begin
         @(posedge clk);
         sv <= 1'b1;
         amp <= a;
         @(posedge clk);
         sv <= 1'b0;
         repeat (4) @(posedge clk);
      end
   endtask : feed

   task automatic count_move(output int n);
      logic [3:0] p;
      p = ana;
      n = 0;
      do begin
         feed(8'h60, 1);
         n++;
      end while (ana === p && n < 200);
      check("gain moved", 1, ana !== p);
      if (ana === p) begin
         complete_run();
      end
   endtask : count_move

   initial begin
      rst = 1'b1;
      {cyc, stb, we, sv, sync_found, rx_restart, ook_mode} = '0;
      {adr, amp, dat_i} = '0;
      sel = 4'hF;
      do_reset();
      check("gains", 8'hFF, {ana, dig});
      for (int i = 0; i < 8; i++) begin
         wb(0, ra[i], 8'h00, 4'hF);
         check("reset value", {24'h0, rv[i]}, rd);
         av = 8'(rnd());
         wb(1, ra[i], av, 4'hF);
         wb(0, ra[i], 8'h00, 4'hF);
         check("readback", {24'h0, (av & rm[i]) | (rv[i] & ~rm[i])}, rd);
      end
      wb(1, 8'h74, av, 4'hF);
      wb(1, 8'h74, ~av, 4'hE);
      wb(0, 8'h74, 8'h00, 4'hF);
      check("ctrl sel0", {24'h0, av}, rd);
      // Settle and averaging counts between two gain steps
      for (int w = 0; w < 4; w++) begin
         do_reset();
         h = rnd() & 3;
         l = w;
         wb(1, 8'h74, 8'((h << 6) | (w << 4) | l), 4'hF);
         wb(1, 8'hC4, 8'h02, 4'hF);
         count_move(n1);
         check("first count", 8 << l, n1);
         check("step", 15 - ((h == 0) ? 2 : 1), ana);
         repeat (2) @(posedge clk);
         check("irq", 1, irq);
         wb(0, 8'hC0, 8'h00, 4'hF);
         check("status gain", 2, rd & 2);
         check("irq clear", 0, irq);
         count_move(n2);
         check("settle count", 8 * (w + 1) + (8 << l), n2);
      end
      // Freeze once sync is found, resume after restart
      do_reset();
      wb(1, 8'h74, 8'h84, 4'hF);
      @(posedge clk);
      sync_found <= 1'b1;
      @(posedge clk);
      sync_found <= 1'b0;
      feed(8'h60, 40);
      check("sync hold", 8'hFF, {ana, dig});
      wb(0, 8'hC0, 8'h00, 4'hF);
      check("status sync", 4, rd & 4);
      @(posedge clk);
      rx_restart <= 1'b1;
      @(posedge clk);
      rx_restart <= 1'b0;
      count_move(n1);
      check("resume", 14, ana);
      feed(8'h21, 16);
      check("deadzone", 14, ana);
      feed(8'h14, 16);
      check("raise", 15, ana);
      // Analogue held, digital keeps stepping
      do_reset();
      wb(1, 8'h74, 8'h88, 4'hF);
      feed(8'h60, 40);
      check("ana hold", 8'hFC, {ana, dig});
      // Full hold with manual override, then absolute sense codes
      do_reset();
      m = 8'(rnd());
      wb(1, 8'hCC, m, 4'hF);
      wb(1, 8'h74, 8'h8C, 4'hF);
      repeat (3) @(posedge clk);
      check("manual", m, {ana, dig});
      wb(1, 8'hCC, 8'hFF, 4'hF);
      for (int t = 0; t < 16; t++) begin
         tc = t[3:0];
         av = (tc == 4'h8) ? 8'h60 : 8'(33 + int'($signed(tc)) + int'(rnd() & 1));
         wb(1, 8'h70, {4'h0, tc}, 4'hF);
         feed(av, 16);
         repeat (3) @(posedge clk);
         check("sense", exp_sense(tc, av, goal_db[3]), cs);
      end
      wb(1, 8'h70, 8'h00, 4'hF);
      wb(1, 8'hC4, 8'h01, 4'hF);
      feed(8'h14, 16);
      wb(0, 8'hC0, 8'h00, 4'hF);
      check("sense low", 0, cs);
      feed(8'h60, 16);
      repeat (3) @(posedge clk);
      check("sense irq", 1, irq);
      wb(0, 8'hC0, 8'h00, 4'hF);
      check("status sense", 1, rd & 1);
      repeat (2) @(posedge clk);
      check("irq clear", 0, irq);
      // Keying decision boundary against each goal
      ook_mode <= 1'b1;
      for (int g = 0; g < 8; g++) begin
         l = rnd() & 3;
         wb(1, 8'h6C, 8'(g), 4'hF);
         wb(1, 8'h74, 8'(8'h8C | l), 4'hF);
         for (int x = 0; x < 2; x++) begin
            av = 8'(int'(goal_db[g]) - 4 * (l + 1) - x);
            feed(av, 1);
            check("ook", exp_ook(av, l, goal_db[g]), ook_data);
         end
      end
      complete_run();
   end
endmodule : testbench
